// [design/tsma_map.sv]
`timescale 1ns/1ps
`include "tsma_cfg.svh"
// What this block does
// - high space line steers to memories
// - control bits 1-0 pick memory target
// - low space line reaches registers only
// - address 12-8 stream, 7-0 channel
// - 2M uses ch 0-31, 4M 0-63
// - 8M uses ch 0-127, 16M all
// - mode bit zero means normal switching
// - translate bit clear ignores high word
// - translate bit set uses high word
// - bit 14 picks variable delay, needs enable
// - bits 13-9 stream, 8-1 channel source
// - mode bit one selects special mode
module tsma_map
    import tsma_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // host parallel port
    input  wire logic        cs_n_in,
    input  wire logic        wr_in,
    input  wire logic        memory_space_select_line_in,
    input  wire logic [12:0] addr_in,
    input  wire logic [15:0] wdata_in,
    output logic      [15:0] rdata_out,
    output logic             rvalid_out,
    output logic             reg_access_out,
    // core side: channel lookup and per-stream rate
    input  wire logic [12:0] core_addr_in,
    input  wire logic [1:0]  core_rate_in,
    output logic             chan_valid_out,
    output logic [2:0]       chan_mode_out,
    output logic             xlate_out,
    output logic [15:0]      xlate_method_out,
    output logic             var_delay_out,
    output logic [4:0]       source_stream_number_out,
    output logic [7:0]       source_channel_number_out,
    output logic [7:0]       message_out
);
    logic [15:0] ctrl_q;
    logic        acc;
    logic        mem_acc;
    logic        we_dm;
    logic        we_cml;
    logic        we_cmh;
    logic [1:0]  sel_q;
    logic        mem_rd_q;
    logic        reg_rd_q;
    logic [15:0] reg_rdata_q;
    logic [15:0] dm_rd;
    logic [15:0] cml_rd;
    logic [15:0] cmh_rd;
    logic [15:0] cml_core;
    logic [15:0] cmh_core;
    logic [12:0] core_addr_q;
    logic [1:0]  core_rate_q;
    logic [7:0]  cm_msg;

    function automatic logic [7:0] last_chan(input logic [1:0] r);
        case (r)
            TSMA_RATE_2M:  last_chan = `TSMA_LAST_CH_2M;
            TSMA_RATE_4M:  last_chan = `TSMA_LAST_CH_4M;
            TSMA_RATE_8M:  last_chan = `TSMA_LAST_CH_8M;
            default:       last_chan = `TSMA_LAST_CH_16M;
        endcase
    endfunction : last_chan

    assign acc     = !cs_n_in;
    assign mem_acc = acc && memory_space_select_line_in;
    assign reg_access_out = acc && !memory_space_select_line_in;
    assign we_dm  = mem_acc && wr_in && (ctrl_q[`TSMA_CTRL_SEL_HI:`TSMA_CTRL_SEL_LO] == `TSMA_SEL_DM);
    assign we_cml = mem_acc && wr_in && (ctrl_q[`TSMA_CTRL_SEL_HI:`TSMA_CTRL_SEL_LO] == `TSMA_SEL_CML);
    assign we_cmh = mem_acc && wr_in && (ctrl_q[`TSMA_CTRL_SEL_HI:`TSMA_CTRL_SEL_LO] == `TSMA_SEL_CMH);

    // control register in register space
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_q <= `TSMA_CTRL_RESET;
        end
        else if (reg_access_out && wr_in && addr_in == `TSMA_REG_CTRL)
        begin
            ctrl_q <= wdata_in;
        end
    end

    // host read pipeline
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sel_q       <= `TSMA_SEL_DM;
            mem_rd_q    <= 1'b0;
            reg_rd_q    <= 1'b0;
            reg_rdata_q <= 16'h0000;
        end
        else
        begin
            sel_q       <= ctrl_q[`TSMA_CTRL_SEL_HI:`TSMA_CTRL_SEL_LO];
            mem_rd_q    <= mem_acc && !wr_in;
            reg_rd_q    <= reg_access_out && !wr_in;
            reg_rdata_q <= (addr_in == `TSMA_REG_CTRL) ? ctrl_q : 16'h0000;
        end
    end

    // stream in 12-8, channel in 7-0, used directly as memory index
    tsma_mem u_dm (.clk_in(clk_in), .we_in(we_dm), .addr_in(addr_in), .wdata_in(wdata_in),
        .rdata_out(dm_rd), .core_addr_in(core_addr_in), .core_data_out());
    tsma_mem u_cml (.clk_in(clk_in), .we_in(we_cml), .addr_in(addr_in), .wdata_in(wdata_in),
        .rdata_out(cml_rd), .core_addr_in(core_addr_in), .core_data_out(cml_core));
    tsma_mem u_cmh (.clk_in(clk_in), .we_in(we_cmh), .addr_in(addr_in), .wdata_in(wdata_in),
        .rdata_out(cmh_rd), .core_addr_in(core_addr_in), .core_data_out(cmh_core));

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out  <= 16'h0000;
            rvalid_out <= 1'b0;
        end
        else
        begin
            rvalid_out <= mem_rd_q || reg_rd_q;
            if (reg_rd_q)
            begin
                rdata_out <= reg_rdata_q;
            end
            else if (mem_rd_q)
            begin
                case (sel_q)
                    `TSMA_SEL_DM:  rdata_out <= dm_rd;
                    `TSMA_SEL_CML: rdata_out <= cml_rd;
                    `TSMA_SEL_CMH: rdata_out <= cmh_rd;
                    default:       rdata_out <= 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            core_addr_q <= 13'h0000;
            core_rate_q <= 2'h0;
        end
        else
        begin
            core_addr_q <= core_addr_in;
            core_rate_q <= core_rate_in;
        end
    end

    assign cm_msg = cml_core[`TSMA_CW_MSG_HI:`TSMA_CW_MSG_LO];

    // decode of the connection word for the core
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            chan_valid_out            <= 1'b0;
            chan_mode_out             <= TSMA_CH_NORMAL;
            xlate_out                 <= 1'b0;
            xlate_method_out          <= 16'h0000;
            var_delay_out             <= 1'b0;
            source_stream_number_out  <= 5'h00;
            source_channel_number_out <= 8'h00;
            message_out               <= 8'h00;
        end
        else
        begin
            chan_valid_out <= (core_addr_q[`TSMA_CHAN_HI:`TSMA_CHAN_LO] <= last_chan(core_rate_q));
            if (!cml_core[`TSMA_CW_MODE_BIT])
            begin
                chan_mode_out             <= TSMA_CH_NORMAL;
                source_stream_number_out  <= cml_core[`TSMA_CW_SS_HI:`TSMA_CW_SS_LO];
                source_channel_number_out <= cml_core[`TSMA_CW_SC_HI:`TSMA_CW_SC_LO];
                var_delay_out <= cml_core[`TSMA_CW_VAR_BIT] && ctrl_q[`TSMA_CTRL_VARIABLE_DELAY_GLOBAL_ENABLE_BIT];
                message_out   <= 8'h00;
            end
            else
            begin
                chan_mode_out <= {1'b1, cml_core[`TSMA_CW_PCC_HI:`TSMA_CW_PCC_LO]};
                var_delay_out <= 1'b0;
                message_out   <= cm_msg;
            end
            xlate_out        <= cml_core[`TSMA_CW_XLATE_BIT];
            xlate_method_out <= cml_core[`TSMA_CW_XLATE_BIT] ? cmh_core : 16'h0000;
        end
    end

    property p_reg_no_mem;
        @(posedge clk_in) disable iff (!rst_n_in)
        reg_access_out |-> !(we_dm || we_cml || we_cmh);
    endproperty
    a_reg_no_mem: assert property (p_reg_no_mem) else $error("register access wrote memory");

    property p_sel;
        @(posedge clk_in) disable iff (!rst_n_in)
        we_cml |-> ctrl_q[`TSMA_CTRL_SEL_HI:`TSMA_CTRL_SEL_LO] == `TSMA_SEL_CML && memory_space_select_line_in;
    endproperty
    a_sel: assert property (p_sel) else $error("low word write without select");

    property p_readback;
        @(posedge clk_in) disable iff (!rst_n_in)
        (mem_acc && !wr_in) |-> ##2 rvalid_out;
    endproperty
    a_readback: assert property (p_readback) else $error("memory read gave no answer");

    property p_xlate;
        @(posedge clk_in) disable iff (!rst_n_in)
        !xlate_out |-> xlate_method_out == 16'h0000;
    endproperty
    a_xlate: assert property (p_xlate) else $error("high word used without translate");

    property p_var;
        @(posedge clk_in) disable iff (!rst_n_in)
        var_delay_out |-> chan_mode_out == TSMA_CH_NORMAL;
    endproperty
    a_var: assert property (p_var) else $error("variable delay outside normal mode");

    property p_valid2m;
        @(posedge clk_in) disable iff (!rst_n_in)
        (core_rate_q == TSMA_RATE_2M && core_addr_q[`TSMA_CHAN_HI:`TSMA_CHAN_LO] > `TSMA_LAST_CH_2M)
            |=> !chan_valid_out;
    endproperty
    a_valid2m: assert property (p_valid2m) else $error("2M channel above 31 valid");

    property p_valid16m;
        @(posedge clk_in) disable iff (!rst_n_in)
        core_rate_q == TSMA_RATE_16M |=> chan_valid_out;
    endproperty
    a_valid16m: assert property (p_valid16m) else $error("16M channel invalid");

    property p_mode;
        @(posedge clk_in) disable iff (!rst_n_in)
        cml_core[`TSMA_CW_MODE_BIT] |=> chan_mode_out != TSMA_CH_NORMAL;
    endproperty
    a_mode: assert property (p_mode) else $error("special mode not entered");
endmodule : tsma_map

// [include/tsma_cfg.svh]
`ifndef TSMA_CFG_SVH
`define TSMA_CFG_SVH
`define TSMA_SPACE_BIT      13
`define TSMA_STREAM_HI      12
`define TSMA_STREAM_LO      8
`define TSMA_CHAN_HI        7
`define TSMA_CHAN_LO        0
`define TSMA_SEL_DM         2'h0
`define TSMA_SEL_CML        2'h1
`define TSMA_SEL_CMH        2'h2
`define TSMA_SEL_RSVD       2'h3
`define TSMA_REG_CTRL       13'h0000
`define TSMA_CTRL_SEL_HI    1
`define TSMA_CTRL_SEL_LO    0
`define TSMA_CW_MSG_HI      10
`define TSMA_CW_MSG_LO      3
`define TSMA_CTRL_VARIABLE_DELAY_GLOBAL_ENABLE_BIT 2
`define TSMA_CTRL_RESET     16'h0000
`define TSMA_CW_XLATE_BIT   15
`define TSMA_CW_VAR_BIT     14
`define TSMA_CW_SS_HI       13
`define TSMA_CW_SS_LO       9
`define TSMA_CW_SC_HI       8
`define TSMA_CW_SC_LO       1
`define TSMA_CW_PCC_HI      2
`define TSMA_CW_PCC_LO      1
`define TSMA_CW_MODE_BIT    0
`define TSMA_LAST_CH_2M     8'h1f
`define TSMA_LAST_CH_4M     8'h3f
`define TSMA_LAST_CH_8M     8'h7f
`define TSMA_LAST_CH_16M    8'hff
`define TSMA_DEPTH          8192
`endif

// [include/tsma_pkg.sv]
package tsma_pkg;
    typedef enum logic [1:0] {
        TSMA_RATE_2M  = 2'b00,
        TSMA_RATE_4M  = 2'b01,
        TSMA_RATE_8M  = 2'b10,
        TSMA_RATE_16M = 2'b11
    } tsma_rate_t;
    typedef enum logic [2:0] {
        TSMA_CH_NORMAL   = 3'b000,
        TSMA_CH_TRISTATE = 3'b100,
        TSMA_CH_MESSAGE  = 3'b101,
        TSMA_CH_BERTEST  = 3'b110,
        TSMA_CH_RSVD     = 3'b111
    } tsma_chmode_t;
endpackage : tsma_pkg

// [design/tsma_mem.sv]
`timescale 1ns/1ps
`include "tsma_cfg.svh"
module tsma_mem
(
    // clock
    input  wire logic        clk_in,
    // host port
    input  wire logic        we_in,
    input  wire logic [12:0] addr_in,
    input  wire logic [15:0] wdata_in,
    output logic      [15:0] rdata_out,
    // core port
    input  wire logic [12:0] core_addr_in,
    output logic      [15:0] core_data_out
);
    logic [15:0] mem [0:`TSMA_DEPTH-1];

    // written words read back unchanged
    always_ff @(posedge clk_in)
    begin
        if (we_in)
        begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out     <= mem[addr_in];
        core_data_out <= mem[core_addr_in];
    end
endmodule : tsma_mem

// [verification/tsma_host.sv]
`timescale 1ns/1ps
module tsma_host
(
    // clock
    input  wire logic        clk_in,
    // answer from the device
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    // parallel bus
    output logic             cs_n_out,
    output logic             wr_out,
    output logic             sel_out,
    output logic      [12:0] addr_out,
    output logic      [15:0] wdata_out
);
    initial
    begin
        cs_n_out  = 1'b1;
        wr_out    = 1'b0;
        sel_out   = 1'b0;
        addr_out  = 13'h0000;
        wdata_out = 16'h0000;
    end
    // one cycle per access, released bus shows inverted select, address and data, write line held
    task acc(input logic w, input logic s, input logic [12:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_in);
        #1;
        cs_n_out  = 1'b0;
        wr_out    = w;
        sel_out   = s;
        addr_out  = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        cs_n_out  = 1'b1;
        sel_out   = ~s;
        addr_out  = ~a;
        wdata_out = ~d;
        q = 16'hxxxx;
        if (!w)
        begin
            @(posedge clk_in);
            #1;
            if (rvalid_in === 1'b1)
                q = rdata_in;
        end
    endtask : acc
endmodule : tsma_host

// [verification/tsma_map_bench.sv]
`timescale 1ns/1ps
module tsma_map_bench;
    import tsma_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cs_n, wr, sel, rv, cv, xl, vd, ra;
    logic [12:0] addr, core_addr_in = 13'h0000;
    logic [1:0]  core_rate_in = 2'h0;
    logic [15:0] wd, rd_q, xm, q;
    logic [2:0]  md;
    logic [4:0]  ss;
    logic [7:0]  sc, msg;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    tsma_host host (.clk_in(clk_in), .rdata_in(rd_q), .rvalid_in(rv), .cs_n_out(cs_n), .wr_out(wr),
                    .sel_out(sel), .addr_out(addr), .wdata_out(wd));
    tsma_map dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .wr_in(wr),
                  .memory_space_select_line_in(sel), .addr_in(addr), .wdata_in(wd), .rdata_out(rd_q),
                  .rvalid_out(rv), .reg_access_out(ra), .core_addr_in(core_addr_in),
                  .core_rate_in(core_rate_in), .chan_valid_out(cv), .chan_mode_out(md), .xlate_out(xl),
                  .xlate_method_out(xm), .var_delay_out(vd), .source_stream_number_out(ss),
                  .source_channel_number_out(sc), .message_out(msg));
    initial forever #20 clk_in = ~clk_in;
    // register-space flag seen mid-cycle during every access
    always @(negedge clk_in)
    begin
        if (cs_n === 1'b0)
            chk({15'h0000, ra}, {15'h0000, !sel});
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task summarize;
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task wrt(input logic s, input logic [12:0] a, input logic [15:0] d);
        host.acc(1'b1, s, a, d, q);
    endtask : wrt
    task rdc(input logic s, input logic [12:0] a, input logic [15:0] e);
        host.acc(1'b0, s, a, 16'h0000, q);
        chk(q, e);
    endtask : rdc
    task look(input logic [12:0] a, input logic [1:0] r);
        @(posedge clk_in);
        #1;
        core_addr_in = a;
        core_rate_in = r;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : look
    initial
    begin
        repeat (20) @(posedge clk_in);
        #1;
        chk({9'h000, rv, cv, xl, vd, md}, 16'h0000);
        rst_n_in = 1'b1;
        wrt(1'b0, 13'h0000, 16'h0001);
        rdc(1'b0, 13'h0000, 16'h0001);
        wrt(1'b1, 13'h0000, 16'h1110);
        wrt(1'b1, 13'h1fff, 16'hfffe);
        wrt(1'b1, 13'h0520, 16'h0a42);
        wrt(1'b0, 13'h0000, 16'h0000);
        wrt(1'b1, 13'h0520, 16'hdead);
        rdc(1'b1, 13'h0520, 16'hdead);
        wrt(1'b0, 13'h0000, 16'h0001);
        rdc(1'b1, 13'h0000, 16'h1110);
        rdc(1'b1, 13'h1fff, 16'hfffe);
        rdc(1'b1, 13'h0520, 16'h0a42);
        wrt(1'b0, 13'h0520, 16'hbeef);
        rdc(1'b0, 13'h0520, 16'h0000);
        rdc(1'b1, 13'h0520, 16'h0a42);
        look(13'h0520, 2'h3);
        chk({13'h0000, md}, {13'h0000, 3'h0});
        chk({xl, vd, 1'b0, ss, sc}, {1'b0, 1'b0, 1'b0, 5'h05, 8'h21});
        chk(xm, 16'h0000);
        for (int r = 0; r < 4; r++)
        begin
            look({5'd5, 8'((32 << r) - 1)}, 2'(r));
            chk({15'h0, cv}, 16'h0001);
            if (r < 3)
            begin
                look({5'd5, 8'(32 << r)}, 2'(r));
                chk({15'h0, cv}, 16'h0000);
            end
        end
        wrt(1'b0, 13'h0000, 16'h0002);
        wrt(1'b1, 13'h0520, 16'h00a5);
        wrt(1'b0, 13'h0000, 16'h0001);
        look(13'h0520, 2'h3);
        chk({15'h0, xl}, 16'h0000);
        wrt(1'b1, 13'h0520, 16'h8a42);
        look(13'h0520, 2'h3);
        chk({xl, xm[14:0]}, 16'h80a5);
        wrt(1'b1, 13'h0520, 16'h4a42);
        look(13'h0520, 2'h3);
        chk({15'h0, vd}, 16'h0000);
        wrt(1'b0, 13'h0000, 16'h0005);
        look(13'h0520, 2'h3);
        chk({15'h0, vd}, 16'h0001);
        for (int p = 0; p < 3; p++)
        begin
            wrt(1'b1, 13'h0520, {5'h00, 8'h3c, 2'(p), 1'b1});
            look(13'h0520, 2'h3);
            chk({5'h00, md, msg}, {5'h00, 3'(4 + p), 8'h3c});
        end
        wrt(1'b0, 13'h0000, 16'h0003);
        wrt(1'b1, 13'h0520, 16'h7777);
        rdc(1'b1, 13'h0520, 16'h0000);
        wrt(1'b0, 13'h0000, 16'h0001);
        rdc(1'b1, 13'h0520, 16'h01e5);
        summarize();
    end
endmodule : tsma_map_bench
